// [rtl/power_sequencer.v]
// sleep/wake negotiation sequencer with its registers on an axi4-lite slave
//
// What this block does
// - sleep indication after programmed sleep symbol count
// - wake acknowledge after programmed wake-request count
// - link drop aborts negotiation when enabled
// - traffic aborts negotiation when enabled
// - autonomous enable resets from strap pins
// - link-up clears autonomous enable; software writes it
// - monitor enable gates fault move to standby
// - negotiated end state: sleep or standby select
// - one-hot self-clearing power commands
// - wake forwarding only while forwarding enabled
//
// Implementation choice: register access over AXI4-Lite.

`include "power_seq_regs.vh"

module power_sequencer #(
  parameter ADDR_W = 12               // byte address width
) (
  input  wire              clk_sys,               // device clock, 10 mhz
  input  wire              rstn,                  // synchronous reset, active low
  input  wire              ce,                    // clock enable
  // axi4-lite slave
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // line side, same clock
  input  wire              sleep_symbol,          // sleep symbol received
  input  wire              wake_symbol,           // wake-request symbol received
  input  wire              link_up,               // link status
  input  wire              tx_activity,           // packet being sent
  input  wire              rx_activity,           // packet being received
  // pins and monitors, asynchronous
  input  wire              over_temp,             // over-temperature alarm
  input  wire              under_volt,            // under-voltage alarm
  input  wire              receive_data3_strap,   // strap selects the source
  input  wire              clock_output_strap,    // strap for autonomous mode
  input  wire              indicator1_strap,      // strap for autonomous mode
  // status outputs
  output reg  [6:0]        power_state_code,      // current power state
  output reg               sleep_symbol_received, // sleep count reached
  output reg               wake_request_ack,      // wake count reached
  output reg               wake_forward,          // wake forwarded
  output reg               send_sleep_request,    // ask partner for sleep
  output reg               send_wake_request,     // wake command issued
  output reg               negotiated_standby,    // standby after negotiation
  output reg               autonomous_mode        // autonomous mode enabled
);

  // ========================================================================
  // address decode
  // ========================================================================
  // true when the byte address hits a register index
  function hit;
    input [ADDR_W-1:0] addr;
    input [9:0]        idx;
    begin
      hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
    end
  endfunction

  // byte-lane merge of a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] data;
    input [1:0]  strb;
    begin
      merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  // ========================================================================
  // input synchronisers for pins
  // ========================================================================
  reg  [4:0] pin_meta_reg;            // first stage, read only by second
  reg  [4:0] pin_sync_reg;            // second stage
  wire       over_temp_s    = pin_sync_reg[4];
  wire       under_volt_s   = pin_sync_reg[3];
  wire       rd3_strap_s    = pin_sync_reg[2];
  wire       clock_output_strap_s = pin_sync_reg[1];
  wire       led1_strap_s   = pin_sync_reg[0];

  // two flops per pin
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      pin_meta_reg <= 5'h00;
      pin_sync_reg <= 5'h00;
    end
    else if (ce)
    begin
      pin_meta_reg <= {over_temp, under_volt, receive_data3_strap,
                       clock_output_strap, indicator1_strap};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ========================================================================
  // registers and bus slave
  // ========================================================================
  reg  [9:0]        sleep_count_reg;  // sleep symbols needed
  reg  [9:0]        wake_count_reg;   // wake-request symbols needed
  reg  [15:0]       neg_ctrl_reg;     // negotiation control
  reg  [8:0]        cmd_reg;          // pending one-hot commands
  reg               wake_fwd_en_reg;  // wake forwarding enable
  reg               link_up_d_reg;    // link status, last cycle
  reg  [ADDR_W-1:0] awaddr_reg;       // held write address
  reg  [31:0]       wdata_reg;        // held write data
  reg  [3:0]        wstrb_reg;        // held write strobes
  reg               aw_full_reg;      // write address held
  reg               w_full_reg;       // write data held
  reg  [6:0]        state_reg;        // power state
  reg  [15:0]       neg_ctrl_next;
  reg  [8:0]        cmd_next;
  reg  [31:0]       rdata_next;
  reg               rd_ok;
  reg               wr_ok;
  reg               strap_live_reg;   // auto bit still follows straps
  wire              do_write  = aw_full_reg && w_full_reg && !s_axi_bvalid;
  wire              link_rise = link_up && !link_up_d_reg;
  // autonomous default depends on straps
  wire              auto_strap_val = rd3_strap_s ? ~clock_output_strap_s : ~led1_strap_s;

  // write decode and next values
  always @*
  begin
    wr_ok         = hit(awaddr_reg, `SLEEP_COUNT_IDX) || hit(awaddr_reg, `WAKE_COUNT_IDX) ||
                    hit(awaddr_reg, `NEG_CTRL_IDX) || hit(awaddr_reg, `CMD_IDX) ||
                    hit(awaddr_reg, `STATUS_IDX) || hit(awaddr_reg, `WAKE_FWD_CTRL_IDX);
    // reserved bits keep reset values
    neg_ctrl_next = neg_ctrl_reg;
    // straps set the auto bit until software or link-up takes over
    if (strap_live_reg)
      neg_ctrl_next[`AUTO_MODE_BIT] = auto_strap_val;
    if (do_write && hit(awaddr_reg, `NEG_CTRL_IDX))
      neg_ctrl_next = (merge16(neg_ctrl_reg, wdata_reg[15:0], wstrb_reg[1:0])
                       & `NEG_CTRL_WMASK) | (neg_ctrl_reg & ~`NEG_CTRL_WMASK);
    // link-up clears autonomous enable
    if (link_rise)
      neg_ctrl_next[`AUTO_MODE_BIT] = 1'b0;
    // commands last one cycle; a new write wins over the clear
    cmd_next = `CMD_RST;
    if (do_write && hit(awaddr_reg, `CMD_IDX))
      cmd_next = {wstrb_reg[1] ? wdata_reg[8] : 1'b0,
                  wstrb_reg[0] ? wdata_reg[7:0] : 8'h00};
  end

  // read decode
  always @*
  begin
    rd_ok      = 1'b1;
    rdata_next = 32'h0;
    if (hit(s_axi_araddr, `SLEEP_COUNT_IDX))
      rdata_next = {22'h0, sleep_count_reg};
    else if (hit(s_axi_araddr, `WAKE_COUNT_IDX))
      rdata_next = {22'h0, wake_count_reg};
    else if (hit(s_axi_araddr, `NEG_CTRL_IDX))
      rdata_next = {16'h0, neg_ctrl_reg};
    else if (hit(s_axi_araddr, `CMD_IDX))
      rdata_next = {23'h0, cmd_reg};
    else if (hit(s_axi_araddr, `STATUS_IDX))
      rdata_next = {25'h0, state_reg};
    else if (hit(s_axi_araddr, `WAKE_FWD_CTRL_IDX))
      rdata_next = {31'h0, wake_fwd_en_reg};
    else
      rd_ok = 1'b0;
  end

  // bus handshakes and register storage
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      s_axi_awready   <= 1'b1;
      s_axi_wready    <= 1'b1;
      s_axi_bvalid    <= 1'b0;
      s_axi_bresp     <= `RESP_OKAY;
      s_axi_arready   <= 1'b1;
      s_axi_rvalid    <= 1'b0;
      s_axi_rresp     <= `RESP_OKAY;
      s_axi_rdata     <= 32'h0;
      aw_full_reg     <= 1'b0;
      w_full_reg      <= 1'b0;
      awaddr_reg      <= {ADDR_W{1'b0}};
      wdata_reg       <= 32'h0;
      wstrb_reg       <= 4'h0;
      sleep_count_reg <= `SLEEP_COUNT_RST;
      wake_count_reg  <= `WAKE_COUNT_RST;
      neg_ctrl_reg    <= `NEG_CTRL_RST;
      cmd_reg         <= `CMD_RST;
      wake_fwd_en_reg <= `WAKE_FWD_RST;
      link_up_d_reg   <= 1'b0;
      strap_live_reg  <= 1'b1;
    end
    else if (ce)
    begin
      link_up_d_reg <= link_up;
      neg_ctrl_reg  <= neg_ctrl_next;
      cmd_reg       <= cmd_next;
      // first control write or link-up ends strap tracking
      if (link_rise || (do_write && hit(awaddr_reg, `NEG_CTRL_IDX)))
        strap_live_reg <= 1'b0;
      // address and data are taken in either order
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_reg    <= s_axi_awaddr;
        aw_full_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        w_full_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      // both held: store and answer
      if (do_write)
      begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        if (hit(awaddr_reg, `SLEEP_COUNT_IDX))
          sleep_count_reg <= {wstrb_reg[1] ? wdata_reg[9:8] : sleep_count_reg[9:8],
                              wstrb_reg[0] ? wdata_reg[7:0] : sleep_count_reg[7:0]};
        if (hit(awaddr_reg, `WAKE_COUNT_IDX))
          wake_count_reg <= {wstrb_reg[1] ? wdata_reg[9:8] : wake_count_reg[9:8],
                             wstrb_reg[0] ? wdata_reg[7:0] : wake_count_reg[7:0]};
        if (hit(awaddr_reg, `WAKE_FWD_CTRL_IDX) && wstrb_reg[0])
          wake_fwd_en_reg <= wdata_reg[0];
      end
      // response taken, reopen write channels
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      // read answers one cycle after the address
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdata_next;
        s_axi_rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ========================================================================
  // symbol counters
  // ========================================================================
  wire sleep_reached;                 // sleep count met this cycle
  wire wake_reached;                  // wake count met this cycle
  wire negotiating = (state_reg == `ST_SLEEP_REQ) || (state_reg == `ST_SLEEP_ACK);
  // link drop or traffic ends a negotiation
  wire abort_neg   = negotiating &&
                     ((neg_ctrl_reg[`LINK_DROP_ABORT_BIT] && !link_up) ||
                      (neg_ctrl_reg[`TRAFFIC_ABORT_BIT] && (tx_activity || rx_activity)));

  // sleep symbols counted against the programmed threshold
  symbol_counter #(.CNT_W(10)) sleep_counter (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .ce        (ce),
    .clear     (abort_neg),
    .symbol    (sleep_symbol),
    .threshold (sleep_count_reg),
    .reached   (sleep_reached)
  );

  // wake-request symbols counted against their threshold
  symbol_counter #(.CNT_W(10)) wake_counter (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .ce        (ce),
    .clear     (1'b0),
    .symbol    (wake_symbol),
    .threshold (wake_count_reg),
    .reached   (wake_reached)
  );

  // ========================================================================
  // power state machine
  // ========================================================================
  reg [6:0] state_next;

  // next state, commands first, then line events, except that in sleep a reached wake count wins over a standby command
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      `ST_NORMAL:
      begin
        if (cmd_reg[`CMD_STANDBY_BIT])
          state_next = `ST_STANDBY;
        else if (cmd_reg[`CMD_SLEEP_BIT])
          state_next = `ST_SLEEP_REQ;
        else if (neg_ctrl_reg[`MONITOR_EN_BIT] && (over_temp_s || under_volt_s))
          state_next = `ST_STANDBY;
        else if (sleep_reached && neg_ctrl_reg[`AUTO_MODE_BIT])
          state_next = `ST_SLEEP_ACK;
      end
      `ST_SLEEP_REQ, `ST_SLEEP_ACK:
      begin
        if (cmd_reg[`CMD_NORMAL_BIT] || abort_neg)
          state_next = `ST_NORMAL;
        else if (state_reg == `ST_SLEEP_REQ && sleep_reached)
          state_next = `ST_SLEEP_ACK;
        else if (state_reg == `ST_SLEEP_ACK)
          state_next = neg_ctrl_reg[`SLEEP_SELECT_BIT] ? `ST_SLEEP : `ST_STANDBY;
      end
      `ST_SLEEP, `ST_STANDBY:
      begin
        if (cmd_reg[`CMD_NORMAL_BIT] || cmd_reg[`CMD_WAKE_BIT] || wake_reached)
          state_next = `ST_NORMAL;
        else if (state_reg == `ST_SLEEP && cmd_reg[`CMD_STANDBY_BIT])
          state_next = `ST_STANDBY;
      end
      default:
        state_next = `ST_NORMAL;
    endcase
  end

  // state and registered outputs
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state_reg             <= `ST_NORMAL;
      power_state_code      <= `ST_NORMAL;
      sleep_symbol_received <= 1'b0;
      wake_request_ack      <= 1'b0;
      wake_forward          <= 1'b0;
      send_sleep_request    <= 1'b0;
      send_wake_request     <= 1'b0;
      negotiated_standby    <= 1'b0;
      autonomous_mode       <= 1'b0;
    end
    else if (ce)
    begin
      state_reg             <= state_next;
      power_state_code      <= state_next;
      sleep_symbol_received <= sleep_reached;
      wake_request_ack      <= wake_reached;
      wake_forward          <= wake_reached && wake_fwd_en_reg;
      send_sleep_request    <= (state_next == `ST_SLEEP_REQ);
      send_wake_request     <= cmd_reg[`CMD_WAKE_BIT];
      // standby reached through negotiation
      if (state_reg == `ST_SLEEP_ACK && state_next == `ST_STANDBY)
        negotiated_standby <= 1'b1;
      else if (state_next != `ST_STANDBY)
        negotiated_standby <= 1'b0;
      autonomous_mode       <= neg_ctrl_next[`AUTO_MODE_BIT];
    end
  end

endmodule // power_sequencer

// [rtl/power_seq_regs.vh]
// register map, fields, resets and state codes of the sleep/wake sequencer
`ifndef POWER_SEQ_REGS_VH
`define POWER_SEQ_REGS_VH

// ==========================================================================
// register indexes (byte address = index * 4)
// ==========================================================================
`define SLEEP_COUNT_IDX      10'h189  // sleep_symbol_receive_count
`define WAKE_COUNT_IDX       10'h18a  // wake_request_receive_count
`define NEG_CTRL_IDX         10'h18b  // sleep_negotiation_control
`define CMD_IDX              10'h18c  // power_command
`define STATUS_IDX           10'h18e  // power_state_status
`define WAKE_FWD_CTRL_IDX    10'h190  // wake_forward_control

// ==========================================================================
// reset values
// ==========================================================================
`define SLEEP_COUNT_RST      10'h040  // 64 sleep symbols
`define WAKE_COUNT_RST       10'h040  // 64 wake-request symbols
`define NEG_CTRL_RST         16'h1c4b // control register, strap bit patched in
`define NEG_CTRL_WMASK       16'h1862 // bits 12, 11, 6, 5, 1 are writable
`define CMD_RST              9'h000
`define WAKE_FWD_RST         1'b1

// ==========================================================================
// field positions
// ==========================================================================
`define LINK_DROP_ABORT_BIT  12
`define TRAFFIC_ABORT_BIT    11
`define AUTO_MODE_BIT        6
`define MONITOR_EN_BIT       5
`define SLEEP_SELECT_BIT     1
`define CMD_NORMAL_BIT       0
`define CMD_SLEEP_BIT        1
`define CMD_STANDBY_BIT      4
`define CMD_WAKE_BIT         7

// ==========================================================================
// power state codes, as shown in power_state_code
// ==========================================================================
`define ST_SLEEP             7'h01
`define ST_STANDBY           7'h02
`define ST_NORMAL            7'h04
`define ST_SLEEP_ACK         7'h08
`define ST_SLEEP_REQ         7'h10

// ==========================================================================
// bus answers
// ==========================================================================
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

// [rtl/symbol_counter.v]
// counts received line symbols and pulses once a programmed number has arrived

module symbol_counter #(
  parameter CNT_W = 10                // width of the count and the threshold
) (
  input  wire             clk_sys,    // device clock
  input  wire             rstn,       // synchronous reset, active low
  input  wire             ce,         // clock enable, freezes state when low
  input  wire             clear,      // restart the count
  input  wire             symbol,     // one received symbol this cycle
  input  wire [CNT_W-1:0] threshold,  // symbols needed
  output reg              reached     // one-cycle pulse when threshold met
);

  // ========================================================================
  // counter
  // ========================================================================
  reg  [CNT_W-1:0] count_reg;         // symbols seen so far
  wire [CNT_W-1:0] count_inc = count_reg + {{(CNT_W-1){1'b0}}, 1'b1}; // count with this symbol

  // count up; a zero threshold fires on the first symbol
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      count_reg <= {CNT_W{1'b0}};
      reached   <= 1'b0;
    end
    else if (ce)
    begin
      if (clear || reached)
      begin
        // restart, so reached lasts one cycle
        count_reg <= {CNT_W{1'b0}};
        reached   <= 1'b0;
      end
      else if (symbol)
      begin
        if (count_inc >= threshold)
        begin
          count_reg <= {CNT_W{1'b0}};
          reached   <= 1'b1;
        end
        else
          count_reg <= count_inc;
      end
    end
  end

endmodule // symbol_counter

// [tb/power_seq_checker.sv]
// concurrent assertions on the ports of the power sequencer
`include "power_seq_regs.vh"
module power_seq_checker (
  input logic        clk_sys, rstn, sleep_symbol, wake_symbol, link_up,
  input logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input logic        s_axi_bvalid, s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic [31:0] s_axi_rdata,
  input logic [6:0]  power_state_code,
  input logic        sleep_symbol_received, wake_request_ack, send_sleep_request,
  input logic        send_wake_request, negotiated_standby, autonomous_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ========================================================================
  // bus answers
  // ========================================================================
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
  property p_wr_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write answer not held");
  // ========================================================================
  // line side and state
  // ========================================================================
  property p_sleep_ind; sleep_symbol_received |-> $past(sleep_symbol, 2); endproperty
  a_sleep_ind: assert property (p_sleep_ind) else $error("sleep indication early");
  property p_wake_ack; wake_request_ack |-> $past(wake_symbol, 2); endproperty
  a_wake_ack: assert property (p_wake_ack) else $error("wake ack without symbol");
  property p_req_lvl;
    1'b1 |-> send_sleep_request == (power_state_code == `ST_SLEEP_REQ);
  endproperty
  a_req_lvl: assert property (p_req_lvl) else $error("sleep request level wrong");
  property p_link_abort;
    (power_state_code inside {`ST_SLEEP_REQ, `ST_SLEEP_ACK}) && !link_up
      |=> power_state_code == `ST_NORMAL;
  endproperty
  a_link_abort: assert property (p_link_abort) else $error("link drop no abort");
  property p_nsb;
    $rose(negotiated_standby) |-> power_state_code == `ST_STANDBY
      && $past(power_state_code) == `ST_SLEEP_ACK;
  endproperty
  a_nsb: assert property (p_nsb) else $error("negotiated standby wrong");
  property p_link_clr; $rose(link_up) |-> ##[1:4] !autonomous_mode; endproperty
  a_link_clr: assert property (p_link_clr) else $error("auto bit not cleared");
  property p_wake_pulse; send_wake_request |=> !send_wake_request; endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
endmodule // power_seq_checker
bind power_sequencer power_seq_checker chk_inst (.*);

// [tb/link_partner.sv]
// link partner model sending sleep and wake-request symbols
module link_partner (
  input  logic clk_sys,
  output logic sleep_symbol,
  output logic wake_symbol
);
  timeunit 1ns;
  timeprecision 1ns;
  initial sleep_symbol = 1'b0;
  initial wake_symbol = 1'b0;
  // one-cycle symbol pulses with idle gaps, line quiet between symbols
  task automatic send(input bit wake, input int n, input int gap);
    repeat (n)
    begin
      @(posedge clk_sys);
      if (wake) wake_symbol <= 1'b1;
      else sleep_symbol <= 1'b1;
      @(posedge clk_sys);
      sleep_symbol <= 1'b0;
      wake_symbol <= 1'b0;
      repeat (gap) @(posedge clk_sys);
    end
  endtask
endmodule // link_partner

// [tb/tb_power_sequencer.sv]
// self-checking bench for the power sequencer
`include "power_seq_regs.vh"
`define CHK(n,e,a) begin compares++; if ((a)!==(e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module tb_power_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rstn = 0, ce = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic receive_data3_strap = 1, clock_output_strap = 0, indicator1_strap = 1;
  logic link_up = 0, tx_activity = 0, rx_activity = 0, over_temp = 0, under_volt = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rd_v;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  rs;
  logic [15:0] seed = 16'h0027;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [6:0] power_state_code;
  wire sleep_symbol_received, wake_request_ack, wake_forward, send_sleep_request;
  wire send_wake_request, negotiated_standby, autonomous_mode, sleep_symbol, wake_symbol;
  int compares = 0, mismatches = 0, cyc = 0, n_ind, n_ack, n_fwd, n_wk, m[int];
  power_sequencer power_sequencer_inst (.*);
  link_partner link_partner_inst (.*);
  always #50 clk_sys = ~clk_sys;
  // pulse counters and run limit
  always @(posedge clk_sys)
  begin
    cyc++;
    n_ind += sleep_symbol_received;
    n_ack += wake_request_ack;
    n_fwd += wake_forward;
    n_wk += send_wake_request;
    if (cyc == 30000)
    begin
      mismatches++;
      summarize();
    end
  end
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one write, each channel released at its own handshake
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge clk_sys);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    forever
    begin
      @(negedge clk_sys);
      aw = s_axi_awready; w = s_axi_wready; b = s_axi_bvalid; rs = s_axi_bresp;
      @(posedge clk_sys);
      if (aw) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
      if (b)
      begin
        s_axi_bready <= 0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [11:0] a);
    logic h, v;
    @(posedge clk_sys);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    forever
    begin
      @(negedge clk_sys);
      h = s_axi_arready; v = s_axi_rvalid;
      rd_v = s_axi_rdata; rs = s_axi_rresp;
      @(posedge clk_sys);
      if (h) s_axi_arvalid <= 0;
      if (v)
      begin
        s_axi_rready <= 0;
        break;
      end
    end
  endtask
  // write a register and update the model
  task automatic wm(input int i, input logic [15:0] d);
    wr({i[9:0], 2'b00}, {16'h0, d});
    `CHK("bresp", `RESP_OKAY, rs)
    if (i == `NEG_CTRL_IDX) m[i] = (m[i] & ~`NEG_CTRL_WMASK) | (d & `NEG_CTRL_WMASK);
    else if (i == `WAKE_FWD_CTRL_IDX) m[i] = d & 1;
    else if (i != `CMD_IDX) m[i] = d & 16'h3ff;
  endtask
  task automatic cr(input int i, input int e);
    rd({i[9:0], 2'b00});
    `CHK("reg", e, rd_v)
  endtask
  task automatic wc(input logic [6:0] e);
    for (int n = 0; n < 60 && power_state_code !== e; n++) @(negedge clk_sys);
    `CHK("state", e, power_state_code)
  endtask
  initial
  begin
    m[`SLEEP_COUNT_IDX] = 64; m[`WAKE_COUNT_IDX] = 64; m[`NEG_CTRL_IDX] = 16'h1c4b;
    m[`CMD_IDX] = 0; m[`WAKE_FWD_CTRL_IDX] = 1;
    repeat (2) @(posedge clk_sys);
    rstn <= 1;
    repeat (4) @(posedge clk_sys);
    foreach (m[i]) cr(i, m[i]);
    rd(12'h000);
    `CHK("rresp", `RESP_SLVERR, rs)
    foreach (m[i])
    begin
      seed = nx(seed);
      wm(i, seed);
      cr(i, m[i]);
    end
    wm(`CMD_IDX, 1);
    wc(`ST_NORMAL);
    $display("test registers done");
    link_up <= 1;
    repeat (4) @(negedge clk_sys);
    `CHK("auto", 1'b0, autonomous_mode)
    wm(`NEG_CTRL_IDX, 16'h1842);
    `CHK("auto", 1'b1, autonomous_mode)
    wm(`SLEEP_COUNT_IDX, 3);
    wm(`WAKE_COUNT_IDX, 2);
    for (int i = 0; i < 2; i++)
    begin
      wm(`NEG_CTRL_IDX, i ? 16'h1800 : 16'h1802);
      wm(`WAKE_FWD_CTRL_IDX, !i);
      n_ind = 0; n_ack = 0; n_fwd = 0; seed = nx(seed);
      wm(`CMD_IDX, 2);
      wc(`ST_SLEEP_REQ);
      link_partner_inst.send(0, 2, seed % 4);
      repeat (4) @(negedge clk_sys);
      `CHK("state", `ST_SLEEP_REQ, power_state_code)
      link_partner_inst.send(0, 1, 0);
      wc(i ? `ST_STANDBY : `ST_SLEEP);
      `CHK("ind", 1, n_ind)
      `CHK("nsb", i[0], negotiated_standby)
      cr(`STATUS_IDX, i ? `ST_STANDBY : `ST_SLEEP);
      link_partner_inst.send(1, 2, seed % 3);
      wc(`ST_NORMAL);
      @(negedge clk_sys);
      `CHK("ack", 1, n_ack)
      `CHK("fwd", !i, n_fwd)
    end
    $display("test negotiation done");
    for (int k = 0; k < 3; k++)
    begin
      wm(`CMD_IDX, 2);
      wc(`ST_SLEEP_REQ);
      @(posedge clk_sys);
      link_up <= k != 0; tx_activity <= k == 1; rx_activity <= k == 2;
      wc(`ST_NORMAL);
      @(posedge clk_sys);
      link_up <= 1; tx_activity <= 0; rx_activity <= 0;
    end
    wm(`NEG_CTRL_IDX, 16'h1000);
    wm(`CMD_IDX, 2);
    wc(`ST_SLEEP_REQ);
    @(posedge clk_sys);
    tx_activity <= 1;
    repeat (5) @(negedge clk_sys);
    `CHK("state", `ST_SLEEP_REQ, power_state_code)
    @(posedge clk_sys);
    link_up <= 0;
    wc(`ST_NORMAL);
    @(posedge clk_sys);
    link_up <= 1; tx_activity <= 0; over_temp <= 1;
    repeat (8) @(negedge clk_sys);
    `CHK("state", `ST_NORMAL, power_state_code)
    @(posedge clk_sys);
    over_temp <= 0;
    wm(`NEG_CTRL_IDX, 16'h1820);
    @(posedge clk_sys);
    under_volt <= 1;
    wc(`ST_STANDBY);
    `CHK("nsb", 1'b0, negotiated_standby)
    @(posedge clk_sys);
    under_volt <= 0;
    wm(`CMD_IDX, 1);
    wc(`ST_NORMAL);
    wm(`CMD_IDX, 16'h10);
    wc(`ST_STANDBY);
    n_wk = 0;
    wm(`CMD_IDX, 16'h80);
    wc(`ST_NORMAL);
    cr(`CMD_IDX, 0);
    `CHK("wake", 1, n_wk)
    $display("test aborts done");
    summarize();
  end
endmodule // tb_power_sequencer
